// ==== rtl/mae_alu.sv ====
`timescale 1ns/100ps
module mae_alu
  import mae_pkg::*;
(
  input wire logic [DATA_W-1:0] a,      // work register operand
  input wire logic [DATA_W-1:0] b,      // memory or immediate operand
  input wire logic cin,                 // carry in for add
  input wire logic do_and,              // bitwise and instead of add
  output logic [DATA_W-1:0] res,        // result byte
  output logic c,                       // carry out of bit 7
  output logic ac,                      // carry out of bit 3
  output logic ov                       // signed overflow
);

  logic [4:0] lo;
  logic [DATA_W:0] sum;

  always_comb
  begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    if (do_and)
    begin
      res = a & b;
      c = 1'b0;
      ac = 1'b0;
      ov = 1'b0;
    end
    else
    begin
      res = sum[DATA_W-1:0];
      c = sum[DATA_W];
      ac = lo[4];
      ov = (a[7] == b[7]) && (sum[7] != a[7]);
    end
  end

endmodule // mae_alu

// ==== rtl/mae_exec.sv ====
// Overview of operation
// - last-page table read: high part to table register, low byte to memory, 2 cycles.
// - sleep enters power-down and updates watchdog-expiry and sleep-entered flags.
// - swap exchanges nibbles of memory byte, to memory or work register, no flags.
// - pre-clears clear expiry and sleep flags only when both run consecutively.
// - conditional skip takes one cycle, two when the next instruction is skipped.
// - any write of the program counter low byte takes two cycles.
// - add with carry sums memory, work register and carry; updates four flags.
// - plain add sums memory and work register; updates four flags.
// - add immediate sums work register and immediate into work register.
// - and with memory into work register updates only null flag.
// - and into memory writes memory and updates only null flag.
// - and immediate into work register updates only null flag.
// - watchdog clear resets counter and clears both flags at once.
`timescale 1ns/100ps
module mae_exec
  import mae_pkg::*;
(
  input wire logic ref_clk,                      // 40 MHz system clock
  input wire logic rst,                          // async reset, active high
  input wire logic instr_valid,                  // instruction offered
  input wire mae_ins_s instr,                    // decoded instruction and operands
  input wire logic [DATA_W-1:0] tbl_ptr,         // table pointer low byte
  input wire logic [PROG_W-1:0] prog_rdata,      // program word, valid with prog_rd.req
  input wire logic wdt_timeout,                  // watchdog expired pulse
  input wire logic wake_pin,                     // asynchronous wake-up request
  output logic instr_ready_q,                    // ready to execute
  output logic [DATA_W-1:0] work_register_q,     // accumulator
  output mae_flags_s flags_q,                    // status flags
  output logic [DATA_W-1:0] table_high_reg_q,    // table read high part
  output mae_memwr_s mem_wr_q,                   // data memory write, one cycle
  output mae_progrd_s prog_rd_q,                 // program memory read request
  output logic power_down_q,                     // sleeping
  output logic wdt_clear_q,                      // watchdog counter clear pulse
  output logic skip_next_q                       // discard the fetched next instruction
);

  mae_state_e state_q, state_d;
  logic ready_d;
  logic [DATA_W-1:0] acc_d, table_high_reg_d;
  mae_flags_s flags_d;
  mae_memwr_s mem_wr_d;
  mae_progrd_s prog_rd_d;
  logic pd_d, wclr_d, skip_d;
  logic [DATA_W-1:0] tbl_dst_q, tbl_dst_d;
  logic wake_m_q, wake_s_q;

  logic take;
  logic pre_fire;
  logic [DATA_W-1:0] alu_b, alu_res;
  logic alu_cin, alu_and, alu_c, alu_ac, alu_ov;
  logic wr_mem, pcl_hit;

  assign take = instr_valid && instr_ready_q;

  mae_alu u_alu (
    .a(work_register_q),
    .b(alu_b),
    .cin(alu_cin),
    .do_and(alu_and),
    .res(alu_res),
    .c(alu_c),
    .ac(alu_ac),
    .ov(alu_ov)
  );

  mae_preclr u_preclr (
    .ref_clk(ref_clk),
    .rst(rst),
    .take(take),
    .is_pre1(instr.op == OP_PRE1),
    .is_pre2(instr.op == OP_PRE2),
    .fire(pre_fire)
  );

  always_comb
  begin
    alu_b = (instr.op == OP_ADD_A_X || instr.op == OP_AND_A_X) ? instr.imm : instr.mdata;
    alu_cin = (instr.op == OP_ADC_A_M || instr.op == OP_ADC_M) && flags_q.c;
    alu_and = instr.op == OP_AND_A_M || instr.op == OP_AND_M || instr.op == OP_AND_A_X;
    wr_mem = instr.op == OP_ADD_M || instr.op == OP_ADC_M || instr.op == OP_AND_M
             || instr.op == OP_SWAP_M;
    pcl_hit = wr_mem && instr.addr == PCL_ADDR;
  end

  always_comb
  begin
    state_d = state_q;
    ready_d = instr_ready_q;
    acc_d = work_register_q;
    table_high_reg_d = table_high_reg_q;
    flags_d = flags_q;
    mem_wr_d = '0;
    prog_rd_d = '0;
    pd_d = power_down_q;
    wclr_d = 1'b0;
    skip_d = 1'b0;
    tbl_dst_d = tbl_dst_q;
    case (state_q)
      ST_EXEC:
      begin
        if (take)
        begin
          case (instr.op)
            OP_ADD_A_M, OP_ADC_A_M, OP_ADD_A_X, OP_ADD_M, OP_ADC_M:
            begin
              flags_d.c = alu_c;
              flags_d.ac = alu_ac;
              flags_d.ov = alu_ov;
              flags_d.z = is_zero_f(alu_res);
              if (!wr_mem)
                acc_d = alu_res;
            end
            OP_AND_A_M, OP_AND_A_X, OP_AND_M:
            begin
              flags_d.z = is_zero_f(alu_res);
              if (!wr_mem)
                acc_d = alu_res;
            end
            OP_SWAP_A_M:
              acc_d = swap_f(instr.mdata);
            OP_CLR_WDT:
            begin
              flags_d.to = 1'b0;
              flags_d.sleep_entered_flag = 1'b0;
              wclr_d = 1'b1;
            end
            OP_PRE1, OP_PRE2:
            begin
              if (pre_fire)
              begin
                flags_d.to = 1'b0;
                flags_d.sleep_entered_flag = 1'b0;
                wclr_d = 1'b1;
              end
            end
            OP_HALT:
            begin
              flags_d.sleep_entered_flag = 1'b1;
              flags_d.to = 1'b0;
              wclr_d = 1'b1;
              pd_d = 1'b1;
              ready_d = 1'b0;
              state_d = ST_SLEEP;
            end
            OP_TBL_LAST:
            begin
              prog_rd_d.req = 1'b1;
              prog_rd_d.addr = {LAST_PAGE_HI, tbl_ptr};
              tbl_dst_d = instr.addr;
              ready_d = 1'b0;
              state_d = ST_SECOND;
            end
            OP_SKIP_Z:
            begin
              if (is_zero_f(instr.mdata))
              begin
                skip_d = 1'b1;
                ready_d = 1'b0;
                state_d = ST_SECOND;
              end
            end
            default:
            begin
            end
          endcase
          if (wr_mem)
          begin
            mem_wr_d.we = 1'b1;
            mem_wr_d.addr = instr.addr;
            mem_wr_d.data = (instr.op == OP_SWAP_M) ? swap_f(instr.mdata) : alu_res;
          end
          if (pcl_hit)
          begin
            ready_d = 1'b0;
            state_d = ST_SECOND;
          end
        end
      end
      ST_SECOND:
      begin
        // the table word is taken in this extra cycle; other two-cycle ops just idle
        if (prog_rd_q.req)
        begin
          table_high_reg_d = prog_rdata[PROG_W-1:DATA_W];
          mem_wr_d.we = 1'b1;
          mem_wr_d.addr = tbl_dst_q;
          mem_wr_d.data = prog_rdata[DATA_W-1:0];
        end
        ready_d = 1'b1;
        state_d = ST_EXEC;
      end
      ST_SLEEP:
      begin
        // a watchdog expiry also wakes; the expiry flag itself is set below
        if (wake_s_q || wdt_timeout)
        begin
          pd_d = 1'b0;
          ready_d = 1'b1;
          state_d = ST_EXEC;
        end
      end
      default:
      begin
        state_d = ST_EXEC;
        ready_d = 1'b1;
      end
    endcase
    // an expiry in the same cycle as any clear still sets the flag
    if (wdt_timeout)
      flags_d.to = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_EXEC;
      instr_ready_q <= 1'b1;
      work_register_q <= ACC_RST;
      table_high_reg_q <= TABLE_HIGH_REG_RST;
      flags_q <= FLAGS_RST;
      mem_wr_q <= '0;
      prog_rd_q <= '0;
      power_down_q <= 1'b0;
      wdt_clear_q <= 1'b0;
      skip_next_q <= 1'b0;
      tbl_dst_q <= '0;
      wake_m_q <= 1'b0;
      wake_s_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      instr_ready_q <= ready_d;
      work_register_q <= acc_d;
      table_high_reg_q <= table_high_reg_d;
      flags_q <= flags_d;
      mem_wr_q <= mem_wr_d;
      prog_rd_q <= prog_rd_d;
      power_down_q <= pd_d;
      wdt_clear_q <= wclr_d;
      skip_next_q <= skip_d;
      tbl_dst_q <= tbl_dst_d;
      wake_m_q <= wake_pin;
      wake_s_q <= wake_m_q;
    end
  end

  // helper copies of the executed instruction, read only by the checks below
  mae_ins_s ins_h_q;
  logic [DATA_W-1:0] acc_h_q;
  logic c_h_q;
  logic [PROG_W-1:0] prog_h;
  logic [DATA_W:0] adc_h;
  // last executed instruction of any kind, forgotten once a pre-clear pair completes
  mae_op_e pre_last_h_q;
  logic pair_h;
  assign pair_h = take && ((instr.op == OP_PRE2 && pre_last_h_q == OP_PRE1)
                  || (instr.op == OP_PRE1 && pre_last_h_q == OP_PRE2));
  assign prog_h = prog_rdata;
  assign adc_h = {1'b0, acc_h_q} + {1'b0, ins_h_q.mdata} + {8'h00, c_h_q};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ins_h_q <= '0;
      acc_h_q <= '0;
      c_h_q <= 1'b0;
      pre_last_h_q <= OP_NOP;
    end
    else
    begin
      ins_h_q <= instr;
      acc_h_q <= work_register_q;
      c_h_q <= flags_q.c;
      if (take)
        pre_last_h_q <= pair_h ? OP_NOP : instr.op;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  tbl_last_read_a: assert property (
    take && instr.op == OP_TBL_LAST |=> !instr_ready_q && prog_rd_q.req
      ##1 instr_ready_q && mem_wr_q.we && mem_wr_q.data == $past(prog_h) % 256
      && table_high_reg_q == $past(prog_h) / 256 && $stable(flags_q))
    else $error("table read wrong");
  sleep_entry_a: assert property (
    take && instr.op == OP_HALT && !wdt_timeout |=> power_down_q && flags_q.sleep_entered_flag
      && !flags_q.to && !instr_ready_q)
    else $error("sleep entry wrong");
  swap_nibbles_a: assert property (
    take && instr.op == OP_SWAP_A_M |=> work_register_q == swap_f(ins_h_q.mdata)
      && flags_q.z == $past(flags_q.z) && flags_q.c == $past(flags_q.c))
    else $error("swap wrong");
  preclear_pair_a: assert property (
    pair_h && !wdt_timeout |=> !flags_q.to && !flags_q.sleep_entered_flag && wdt_clear_q)
    else $error("pre-clear pair did not clear");
  preclear_repeat_a: assert property (
    take && instr.op == OP_PRE1 && pre_last_h_q == OP_PRE1 && !wdt_timeout
      |=> $stable(flags_q) && !wdt_clear_q)
    else $error("repeated pre-clear had effect");
  skip_cycles_a: assert property (
    take && instr.op == OP_SKIP_Z |=> skip_next_q == !instr_ready_q
      && skip_next_q == is_zero_f(ins_h_q.mdata) ##1 instr_ready_q)
    else $error("skip timing wrong");
  pcl_two_cycle_a: assert property (
    take && pcl_hit |=> !instr_ready_q && mem_wr_q.we ##1 instr_ready_q)
    else $error("pcl write not two cycles");
  add_carry_a: assert property (
    take && instr.op == OP_ADC_A_M |=> work_register_q == adc_h[DATA_W-1:0]
      && flags_q.c == adc_h[DATA_W] && flags_q.z == (work_register_q == 8'h00))
    else $error("add with carry wrong");
  and_null_only_a: assert property (
    take && instr.op == OP_AND_A_X |=> work_register_q == (acc_h_q & ins_h_q.imm)
      && flags_q.z == (work_register_q == 8'h00) && flags_q.c == c_h_q)
    else $error("and immediate wrong");
  clr_wdt_a: assert property (
    take && instr.op == OP_CLR_WDT && !wdt_timeout |=> wdt_clear_q && !flags_q.to
      && !flags_q.sleep_entered_flag && instr_ready_q)
    else $error("watchdog clear wrong");

  tbl_read_c: cover property (take && instr.op == OP_TBL_LAST ##2 mem_wr_q.we);
  skip_taken_c: cover property (take && instr.op == OP_SKIP_Z ##1 skip_next_q);
  pair_clear_c: cover property (take && instr.op == OP_PRE2 && pre_fire);
  wake_c: cover property (power_down_q ##1 !power_down_q);

endmodule // mae_exec

// ==== rtl/mae_pkg.sv ====
package mae_pkg;

  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PROG_AW = 12;
  localparam int PAGE_W = PROG_AW - DATA_W;
  // the last page is the one whose upper address bits are all ones
  localparam logic [PAGE_W-1:0] LAST_PAGE_HI = 4'hF;
  // data memory address at which the program counter low byte is mapped
  localparam logic [DATA_W-1:0] PCL_ADDR = 8'h06;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_HIGH_REG_RST = 8'h00;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_ADD_A_M  = 5'h01,
    OP_ADD_M    = 5'h02,
    OP_ADC_A_M  = 5'h03,
    OP_ADC_M    = 5'h04,
    OP_ADD_A_X  = 5'h05,
    OP_AND_A_M  = 5'h06,
    OP_AND_M    = 5'h07,
    OP_AND_A_X  = 5'h08,
    OP_SWAP_M   = 5'h09,
    OP_SWAP_A_M = 5'h0A,
    OP_CLR_WDT  = 5'h0B,
    OP_PRE1     = 5'h0C,
    OP_PRE2     = 5'h0D,
    OP_HALT     = 5'h0E,
    OP_TBL_LAST = 5'h0F,
    OP_SKIP_Z   = 5'h10
  } mae_op_e;

  typedef enum logic [2:0] {
    ST_EXEC   = 3'h1,
    ST_SECOND = 3'h2,
    ST_SLEEP  = 3'h4
  } mae_state_e;

  typedef struct packed {
    mae_op_e op;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] mdata;
    logic [DATA_W-1:0] imm;
  } mae_ins_s;

  typedef struct packed {
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic to;
    logic sleep_entered_flag;
  } mae_flags_s;

  localparam mae_flags_s FLAGS_RST = 6'h00;

  typedef struct packed {
    logic we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mae_memwr_s;

  typedef struct packed {
    logic req;
    logic [PROG_AW-1:0] addr;
  } mae_progrd_s;

  function automatic logic is_zero_f(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  function automatic logic [DATA_W-1:0] swap_f(input logic [DATA_W-1:0] v);
    return {v[3:0], v[7:4]};
  endfunction

endpackage

// ==== rtl/mae_preclr.sv ====
`timescale 1ns/100ps
module mae_preclr
  import mae_pkg::*;
(
  input wire logic ref_clk,    // system clock
  input wire logic rst,        // async reset, active high
  input wire logic take,       // an instruction is executed this cycle
  input wire logic is_pre1,    // it is the first pre-clear
  input wire logic is_pre2,    // it is the second pre-clear
  output logic fire            // pair completed, clear flags now
);

  // remembers which half of the pair ran last; any other instruction forgets
  logic pre1_q, pre1_d;
  logic pre2_q, pre2_d;

  always_comb
  begin
    fire = take && ((is_pre2 && pre1_q) || (is_pre1 && pre2_q));
    pre1_d = pre1_q;
    pre2_d = pre2_q;
    if (take)
    begin
      pre1_d = is_pre1 && !fire;
      pre2_d = is_pre2 && !fire;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end
    else
    begin
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
    end
  end

endmodule // mae_preclr

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench
  import mae_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic wdt_timeout = 1'b0;
  logic wake_pin = 1'b0;
  mae_ins_s instr = '0;
  logic [DATA_W-1:0] tbl_ptr = 8'h00;
  logic [PROG_W-1:0] tbl_word = 16'h0000;
  logic [PROG_W-1:0] prog_rdata;
  logic instr_ready_q;
  logic [DATA_W-1:0] work_register_q;
  mae_flags_s flags_q;
  logic [DATA_W-1:0] table_high_reg_q;
  mae_memwr_s mem_wr_q;
  mae_progrd_s prog_rd_q;
  logic power_down_q;
  logic wdt_clear_q;
  logic skip_next_q;
  int mismatches = 0;
  int checks = 0;
  logic [DATA_W-1:0] exp_acc = 8'h00;
  mae_flags_s ef = FLAGS_RST;

  // word valid only while requested, inverted otherwise so a late sample shows
  assign prog_rdata = prog_rd_q.req ? tbl_word : ~tbl_word;

  mae_exec dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .tbl_ptr(tbl_ptr), .prog_rdata(prog_rdata), .wdt_timeout(wdt_timeout),
    .wake_pin(wake_pin), .instr_ready_q(instr_ready_q), .work_register_q(work_register_q),
    .flags_q(flags_q), .table_high_reg_q(table_high_reg_q), .mem_wr_q(mem_wr_q),
    .prog_rd_q(prog_rd_q), .power_down_q(power_down_q), .wdt_clear_q(wdt_clear_q),
    .skip_next_q(skip_next_q));

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready_q !== 1'b1)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 40)
      begin
        mismatches++;
        $display("unexpected at %0t: ready never returned", $time);
        wrap_up();
      end
    end
  endtask

  // called at a falling edge, returns at the falling edge after the take;
  // one idle cycle first so valid is never lowered and raised in one step
  task automatic issue(input mae_op_e op, input logic [7:0] a, m, x);
    @(negedge ref_clk);
    wait_ready();
    instr_valid = 1'b1;
    instr = '{op, a, m, x};
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask

  task automatic op_chk(input mae_op_e op, input logic [7:0] a, m, x);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic [7:0] r;
    logic cin;
    logic mw;
    b = (op inside {OP_ADD_A_X, OP_AND_A_X}) ? x : m;
    cin = (op inside {OP_ADC_A_M, OP_ADC_M}) ? ef.c : 1'b0;
    mw = op inside {OP_ADD_M, OP_ADC_M, OP_AND_M, OP_SWAP_M};
    if (op inside {OP_AND_A_M, OP_AND_M, OP_AND_A_X})
      r = exp_acc & b;
    else if (op inside {OP_SWAP_M, OP_SWAP_A_M})
      r = {m[3:0], m[7:4]};
    else
    begin
      s = exp_acc + b + cin;
      h = exp_acc[3:0] + b[3:0] + cin;
      r = s[7:0];
      ef.c = s[8];
      ef.ac = h[4];
      ef.ov = (exp_acc[7] == b[7]) && (r[7] != b[7]);
    end
    if (!(op inside {OP_SWAP_M, OP_SWAP_A_M}))
      ef.z = (r == 8'h00);
    if (!mw)
      exp_acc = r;
    issue(op, a, m, x);
    chk(work_register_q, exp_acc, "acc");
    chk(flags_q, ef, "flags");
    chk(mem_wr_q.we, mw, "memory write strobe");
    if (mw)
      chk({mem_wr_q.addr, mem_wr_q.data}, {a, r}, "memory write");
    // a write to the program counter low byte holds the port for a second cycle
    chk(instr_ready_q, !(mw && a == PCL_ADDR), "ready after op");
  endtask

  task automatic t_alu();
    op_chk(OP_ADD_A_X, 8'h00, 8'h00, 8'h7F);
    op_chk(OP_ADD_A_M, 8'h10, 8'h01, 8'h00);
    op_chk(OP_ADC_A_M, 8'h11, 8'h80, 8'h00);
    op_chk(OP_ADC_M, 8'h20, 8'h0F, 8'h00);
    op_chk(OP_ADD_M, 8'h21, 8'hF0, 8'h00);
    op_chk(OP_ADD_A_X, 8'h00, 8'h00, 8'hF3);
    op_chk(OP_AND_A_M, 8'h12, 8'h3C, 8'h00);
    op_chk(OP_AND_M, 8'h22, 8'h0F, 8'h00);
    op_chk(OP_AND_A_X, 8'h00, 8'h00, 8'hC0);
    op_chk(OP_SWAP_A_M, 8'h13, 8'h3C, 8'h00);
    op_chk(OP_SWAP_M, 8'h23, 8'hA5, 8'h00);
    op_chk(OP_ADD_M, PCL_ADDR, 8'h01, 8'h00);
    @(negedge ref_clk);
    chk(instr_ready_q, 1'b1, "ready after second cycle");
    issue(OP_NOP, 8'h00, 8'h00, 8'h00);
    chk({instr_ready_q, flags_q}, {1'b1, ef}, "nop single cycle");
  endtask

  task automatic t_skip();
    issue(OP_SKIP_Z, 8'h50, 8'h00, 8'h00);
    chk({skip_next_q, instr_ready_q}, 2'b10, "skip taken");
    @(negedge ref_clk);
    chk({skip_next_q, instr_ready_q}, 2'b01, "skip done");
    issue(OP_SKIP_Z, 8'h50, 8'h01, 8'h00);
    chk({skip_next_q, instr_ready_q, flags_q}, {2'b01, ef}, "no skip");
  endtask

  task automatic t_table();
    tbl_ptr = 8'h5A;
    tbl_word = 16'h3C96;
    issue(OP_TBL_LAST, 8'h40, 8'h00, 8'h00);
    chk({prog_rd_q.req, instr_ready_q}, 2'b10, "table fetch");
    chk(prog_rd_q.addr, {LAST_PAGE_HI, 8'h5A}, "last page address");
    @(negedge ref_clk);
    chk({mem_wr_q.we, mem_wr_q.addr, mem_wr_q.data}, {1'b1, 16'h4096}, "table low");
    chk({table_high_reg_q, instr_ready_q}, {8'h3C, 1'b1}, "table high");
    chk(flags_q, ef, "table flags");
  endtask

  task automatic nap(input logic by_pin);
    issue(OP_HALT, 8'h00, 8'h00, 8'h00);
    ef.sleep_entered_flag = 1'b1;
    ef.to = 1'b0;
    chk({power_down_q, wdt_clear_q, instr_ready_q}, 3'b110, "sleep entry");
    chk(flags_q, ef, "sleep flags");
    @(negedge ref_clk);
    // offers made while asleep must be ignored
    instr_valid = 1'b1;
    instr = '{OP_ADD_A_X, 8'h00, 8'h00, 8'h11};
    repeat (3) @(negedge ref_clk);
    instr_valid = 1'b0;
    chk({power_down_q, work_register_q}, {1'b1, exp_acc}, "asleep");
    if (by_pin)
      wake_pin = 1'b1;
    else
      wdt_timeout = 1'b1;
    @(negedge ref_clk);
    wdt_timeout = 1'b0;
    if (!by_pin)
      ef.to = 1'b1;
    wait_ready();
    wake_pin = 1'b0;
    chk({power_down_q, flags_q}, {1'b0, ef}, "after wake");
  endtask

  task automatic t_watchdog();
    nap(1'b1);
    nap(1'b0);
    issue(OP_PRE1, 8'h00, 8'h00, 8'h00);
    chk(flags_q, ef, "first pre-clear alone");
    issue(OP_PRE1, 8'h00, 8'h00, 8'h00);
    chk(flags_q, ef, "repeated pre-clear");
    issue(OP_NOP, 8'h00, 8'h00, 8'h00);
    issue(OP_PRE2, 8'h00, 8'h00, 8'h00);
    chk(flags_q, ef, "pair broken by nop");
    issue(OP_PRE1, 8'h00, 8'h00, 8'h00);
    ef.to = 1'b0;
    ef.sleep_entered_flag = 1'b0;
    chk(flags_q, ef, "pair completed");
    nap(1'b0);
    issue(OP_CLR_WDT, 8'h00, 8'h00, 8'h00);
    ef.to = 1'b0;
    ef.sleep_entered_flag = 1'b0;
    chk({wdt_clear_q, flags_q}, {1'b1, ef}, "watchdog clear");
  endtask

  initial
  begin
    repeat (4) @(negedge ref_clk);
    chk({instr_ready_q, work_register_q, table_high_reg_q}, {1'b1, ACC_RST, TABLE_HIGH_REG_RST}, "reset");
    chk({flags_q, mem_wr_q.we, prog_rd_q.req, power_down_q}, {FLAGS_RST, 3'b000}, "reset");
    rst = 1'b0;
    @(negedge ref_clk);
    t_alu();
    t_skip();
    t_table();
    t_watchdog();
    wrap_up();
  end
endmodule // testbench
